// file: dcid_pkg.sv
package dcid_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Word offsets inside the top 4KB block
    localparam logic [11:0] OFF_INTEG_CTRL  = 12'hF00;
    localparam logic [11:0] OFF_CLAIM_SET   = 12'hFA0;
    localparam logic [11:0] OFF_CLAIM_CLR   = 12'hFA4;
    localparam logic [11:0] OFF_DEV_AFF0    = 12'hFA8;
    localparam logic [11:0] OFF_DEV_AFF1    = 12'hFAC;
    localparam logic [11:0] OFF_LOCK_ACCESS = 12'hFB0;
    localparam logic [11:0] OFF_LOCK_STATE  = 12'hFB4;
    localparam logic [11:0] OFF_AUTH_STATE  = 12'hFB8;
    localparam logic [11:0] OFF_DEV_ARCH    = 12'hFBC;
    localparam logic [11:0] OFF_DEV_CFG2    = 12'hFC0;
    localparam logic [11:0] OFF_DEV_CFG1    = 12'hFC4;
    localparam logic [11:0] OFF_DEV_CFG0    = 12'hFC8;
    localparam logic [11:0] OFF_DEV_TYPE    = 12'hFCC;
    localparam logic [11:0] OFF_PERIPH_ID4  = 12'hFD0;
    localparam logic [11:0] OFF_PERIPH_ID5  = 12'hFD4;
    localparam logic [11:0] OFF_PERIPH_ID6  = 12'hFD8;
    localparam logic [11:0] OFF_PERIPH_ID7  = 12'hFDC;
    localparam logic [11:0] OFF_PERIPH_ID0  = 12'hFE0;
    localparam logic [11:0] OFF_PERIPH_ID1  = 12'hFE4;
    localparam logic [11:0] OFF_PERIPH_ID2  = 12'hFE8;
    localparam logic [11:0] OFF_PERIPH_ID3  = 12'hFEC;
    localparam logic [11:0] OFF_COMP_ID0    = 12'hFF0;
    localparam logic [11:0] OFF_COMP_ID1    = 12'hFF4;
    localparam logic [11:0] OFF_COMP_ID2    = 12'hFF8;
    localparam logic [11:0] OFF_COMP_ID3    = 12'hFFC;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and sizes
    localparam int          BLOCK_SHIFT     = 12;
    localparam int          LOCK_IMPL_BIT   = 0;
    localparam int          LOCK_LOCKED_BIT = 1;
    localparam int          LOCK_NARROW_BIT = 2;
    localparam int          CLASS_LSB       = 4;
    localparam logic [3:0]  CLASS_ROM_TABLE = 4'h1;
    localparam logic [3:0]  CLASS_DEBUG     = 4'h9;
    localparam logic [3:0]  CLASS_SYSTEM    = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        INTEG_CTRL_RST  = 1'b0;
    localparam logic [31:0] CLAIM_RST       = 32'h0000_0000;
    localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
    localparam logic [7:0]  AUTH_SYNC_RST   = 8'h00;

endpackage

// file: dcid_claim_tags.sv
`timescale 1ns/10ps
module dcid_claim_tags
    import dcid_pkg::*;
#(
    parameter int CLAIM_W = 4
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Write strobes from the bus slave
    input  wire logic        set_we_in,
    input  wire logic        clr_we_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    // Tag state
    output logic      [31:0] tags_out,
    output logic      [31:0] impl_mask_out
);
    // Bits above CLAIM_W never store anything
    localparam logic [31:0] CLAIM_MASK = 32'((64'h1 << CLAIM_W) - 64'h1);

    typedef struct packed {
        logic [31:0] tags_r;
    } dcid_claim_s;

    dcid_claim_s cur;
    dcid_claim_s nxt;
    logic [31:0] lane_mask;

    always_comb begin
        lane_mask = {{8{wstrb_in[3]}}, {8{wstrb_in[2]}}, {8{wstrb_in[1]}}, {8{wstrb_in[0]}}};
        nxt = cur;
        if (set_we_in) begin
            nxt.tags_r = cur.tags_r | (wdata_in & lane_mask & CLAIM_MASK);
        end else if (clr_we_in) begin
            nxt.tags_r = cur.tags_r & ~(wdata_in & lane_mask & CLAIM_MASK);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cur <= CLAIM_RST;
        end else begin
            cur <= nxt;
        end
    end

    assign tags_out      = cur.tags_r;
    assign impl_mask_out = CLAIM_MASK;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Lanes not strobed must be left alone, so the lane mask is part of the check
    chk_claim_set_bits: assert property (
        set_we_in |=> (tags_out & $past(wdata_in) & $past(lane_mask) & CLAIM_MASK)
            == ($past(wdata_in) & $past(lane_mask) & CLAIM_MASK))
        else $error("claim set lost a bit");

    chk_claim_clr_bits: assert property (
        clr_we_in |=> (tags_out & $past(wdata_in) & $past(lane_mask)) == 32'h0)
        else $error("claim clear left a bit");

    chk_claim_unimpl_zero: assert property (
        (tags_out & ~CLAIM_MASK) == 32'h0)
        else $error("unimplemented claim bit set");
endmodule

// file: dcid_lock_ctrl.sv
`timescale 1ns/10ps
module dcid_lock_ctrl
    import dcid_pkg::*;
#(
    parameter logic        LOCK_IMPL = 1'b1,
    parameter logic [31:0] LOCK_KEY  = 32'h5A5A_5A5A
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Write to the lock access word
    input  wire logic        we_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    // Lock status
    output logic             locked_out
);
    typedef struct packed {
        logic locked_r;
    } dcid_lock_s;

    dcid_lock_s cur;
    dcid_lock_s nxt;

    // Key must arrive as one full word; partial lanes relock
    always_comb begin
        nxt = cur;
        if (we_in && LOCK_IMPL) begin
            nxt.locked_r = !(wdata_in == LOCK_KEY && wstrb_in == 4'hF);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cur <= LOCK_IMPL;
        end else begin
            cur <= nxt;
        end
    end

    assign locked_out = cur.locked_r;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_lock_key_open: assert property (
        we_in && wdata_in == LOCK_KEY && wstrb_in == 4'hF |=> !locked_out)
        else $error("key did not unlock");

    chk_lock_bad_key: assert property (
        we_in && LOCK_IMPL && wdata_in != LOCK_KEY |=> locked_out)
        else $error("wrong key did not lock");
endmodule

// file: dcid_regbank.sv
`timescale 1ns/10ps
module dcid_regbank
    import dcid_pkg::*;
#(
    parameter int          ADDR_W       = 12,
    parameter int          NUM_BLOCKS   = 1,
    parameter int          CLAIM_W      = 4,
    parameter logic        LOCK_IMPL    = 1'b1,
    parameter logic [31:0] LOCK_KEY     = 32'h5A5A_5A5A,
    parameter logic [31:0] DEV_AFF0     = 32'h0000_0000,
    parameter logic [31:0] DEV_AFF1     = 32'h0000_0000,
    parameter logic [31:0] DEV_ARCH     = 32'h0000_0000,
    parameter logic [31:0] DEV_CFG0     = 32'h0000_0000,
    parameter logic [31:0] DEV_CFG1     = 32'h0000_0000,
    parameter logic [31:0] DEV_CFG2     = 32'h0000_0000,
    parameter logic [7:0]  DEV_TYPE     = 8'h00,
    // Arbitrary identification bytes, {id7 .. id0}
    parameter logic [63:0] PERIPH_IDS   = 64'h0000_0000_0000_0000,
    parameter logic [3:0]  COMP_CLASS   = 4'h9,
    // Arbitrary preamble, {ident3, ident2, ident1[3:0], ident0}
    parameter logic [27:0] PREAMBLE     = 28'h000_0000
) (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Debug APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Authentication levels from the security logic, asynchronous
    input  wire logic [7:0]        auth_state_in,
    // Controls toward the component
    output logic                   integration_mode_out,
    output logic      [31:0]       claim_tags_out,
    output logic                   locked_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] prdata_r;
        logic [7:0]  auth_meta_r;
        logic [7:0]  auth_sync_r;
        logic        integ_r;
    } dcid_bank_s;

    dcid_bank_s  cur;
    dcid_bank_s  nxt;

    logic        top_blk;
    logic [11:0] word_off;
    logic        rd_setup;
    logic        wr_acc;
    logic        rd_hit;
    logic [31:0] rd_word;
    logic [31:0] claim_tags;
    logic [31:0] claim_mask;
    logic        locked;
    logic        claim_set_we;
    logic        claim_clr_we;
    logic        lock_we;
    logic [2:0]  lock_word;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Upper address bits select the block; only the last one holds the bank
    assign top_blk  = (paddr_in >> BLOCK_SHIFT) == ADDR_W'(NUM_BLOCKS - 1);
    // Byte bits are dropped: every access addresses a whole word; write strobes pick the lanes
    assign word_off = {paddr_in[11:2], 2'b00};
    assign rd_setup = psel_in && !penable_in && !pwrite_in;
    assign wr_acc   = psel_in && penable_in && pwrite_in && top_blk;

    // Locked bank ignores every write but the key word
    assign claim_set_we = wr_acc && !locked && word_off == OFF_CLAIM_SET;
    assign claim_clr_we = wr_acc && !locked && word_off == OFF_CLAIM_CLR;
    assign lock_we      = wr_acc && word_off == OFF_LOCK_ACCESS;

    assign lock_word = 3'({1'b0, locked, LOCK_IMPL});

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (!top_blk) begin
            // Lower blocks and device-specific space hold nothing here
            rd_hit = 1'b0;
        end else begin
            case (word_off)
                OFF_INTEG_CTRL: begin
                    rd_word = {31'h0, cur.integ_r};
                end
                OFF_CLAIM_SET: begin
                    rd_word = claim_mask;
                end
                OFF_CLAIM_CLR: begin
                    rd_word = claim_tags;
                end
                OFF_DEV_AFF0: begin
                    rd_word = DEV_AFF0;
                end
                OFF_DEV_AFF1: begin
                    rd_word = DEV_AFF1;
                end
                OFF_LOCK_ACCESS: begin
                    rd_word = 32'h0;
                end
                OFF_LOCK_STATE: begin
                    rd_word = {29'h0, lock_word};
                end
                OFF_AUTH_STATE: begin
                    rd_word = {24'h0, cur.auth_sync_r};
                end
                OFF_DEV_ARCH: begin
                    rd_word = DEV_ARCH;
                end
                OFF_DEV_CFG2: begin
                    rd_word = DEV_CFG2;
                end
                OFF_DEV_CFG1: begin
                    rd_word = DEV_CFG1;
                end
                OFF_DEV_CFG0: begin
                    rd_word = DEV_CFG0;
                end
                OFF_DEV_TYPE: begin
                    rd_word = {24'h0, DEV_TYPE};
                end
                OFF_PERIPH_ID4: begin
                    rd_word = {24'h0, PERIPH_IDS[39:32]};
                end
                OFF_PERIPH_ID5: begin
                    rd_word = {24'h0, PERIPH_IDS[47:40]};
                end
                OFF_PERIPH_ID6: begin
                    rd_word = {24'h0, PERIPH_IDS[55:48]};
                end
                OFF_PERIPH_ID7: begin
                    rd_word = {24'h0, PERIPH_IDS[63:56]};
                end
                OFF_PERIPH_ID0: begin
                    rd_word = {24'h0, PERIPH_IDS[7:0]};
                end
                OFF_PERIPH_ID1: begin
                    rd_word = {24'h0, PERIPH_IDS[15:8]};
                end
                OFF_PERIPH_ID2: begin
                    rd_word = {24'h0, PERIPH_IDS[23:16]};
                end
                OFF_PERIPH_ID3: begin
                    rd_word = {24'h0, PERIPH_IDS[31:24]};
                end
                OFF_COMP_ID0: begin
                    rd_word = {24'h0, PREAMBLE[7:0]};
                end
                OFF_COMP_ID1: begin
                    rd_word = {24'h0, COMP_CLASS, PREAMBLE[11:8]};
                end
                OFF_COMP_ID2: begin
                    rd_word = {24'h0, PREAMBLE[19:12]};
                end
                OFF_COMP_ID3: begin
                    rd_word = {24'h0, PREAMBLE[27:20]};
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt = cur;
        // Two stages before anything reads the authentication levels
        nxt.auth_meta_r = auth_state_in;
        nxt.auth_sync_r = cur.auth_meta_r;
        // Read word captured in setup so access phase sees a flop
        if (rd_setup) begin
            nxt.prdata_r = rd_word;
        end
        // Bit 0 lives in the lowest byte lane
        if (wr_acc && !locked && word_off == OFF_INTEG_CTRL && pstrb_in[0]) begin
            nxt.integ_r = pwdata_in[0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cur <= {RDATA_RST, AUTH_SYNC_RST, AUTH_SYNC_RST, INTEG_CTRL_RST};
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submodules

    dcid_claim_tags #(
        .CLAIM_W       (CLAIM_W)
    ) u_claim (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .set_we_in     (claim_set_we),
        .clr_we_in     (claim_clr_we),
        .wdata_in      (pwdata_in),
        .wstrb_in      (pstrb_in),
        .tags_out      (claim_tags),
        .impl_mask_out (claim_mask)
    );

    dcid_lock_ctrl #(
        .LOCK_IMPL     (LOCK_IMPL),
        .LOCK_KEY      (LOCK_KEY)
    ) u_lock (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .we_in         (lock_we),
        .wdata_in      (pwdata_in),
        .wstrb_in      (pstrb_in),
        .locked_out    (locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait states; no access is ever refused
    assign pready_out           = psel_in && penable_in;
    assign pslverr_out          = 1'b0;
    assign prdata_out           = cur.prdata_r;
    assign integration_mode_out = cur.integ_r;
    assign claim_tags_out       = claim_tags;
    assign locked_out           = locked;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rd_setup_at(logic [11:0] off);
        psel_in && !penable_in && !pwrite_in && top_blk && word_off == off;
    endsequence

    sequence s_access;
        psel_in && penable_in;
    endsequence

    chk_unmapped_raz: assert property (
        (psel_in && !penable_in && !pwrite_in && !rd_hit) ##1 s_access |-> prdata_out == 32'h0)
        else $error("unmapped read not zero");

    chk_low_block_empty: assert property (
        (psel_in && !penable_in && !pwrite_in && !top_blk) ##1 s_access
            |-> prdata_out == 32'h0)
        else $error("lower block returned data");

    chk_class_legal: assert property (
        s_rd_setup_at(OFF_COMP_ID1) ##1 s_access
            |-> prdata_out[7:4] inside {CLASS_ROM_TABLE, CLASS_DEBUG, CLASS_SYSTEM})
        else $error("component class not legal");

    chk_ident_upper_zero: assert property (
        s_rd_setup_at(OFF_PERIPH_ID0) ##1 s_access
            |-> prdata_out == {24'h0, PERIPH_IDS[7:0]})
        else $error("ident word wrong");

    chk_integ_write: assert property (
        wr_acc && !locked && word_off == OFF_INTEG_CTRL && pstrb_in[0]
            |=> integration_mode_out == $past(pwdata_in[0]))
        else $error("integration bit not written");

    chk_lock_blocks_write: assert property (
        wr_acc && locked && word_off != OFF_LOCK_ACCESS
            |=> $stable(integration_mode_out) && $stable(claim_tags_out))
        else $error("write passed while locked");

    chk_lock_state_read: assert property (
        s_rd_setup_at(OFF_LOCK_STATE) ##1 s_access
            |-> prdata_out[31:3] == 29'h0 && prdata_out[LOCK_LOCKED_BIT] == locked
                && prdata_out[LOCK_NARROW_BIT] == 1'b0)
        else $error("lock state read wrong");

    chk_integ_readback: assert property (
        s_rd_setup_at(OFF_INTEG_CTRL) ##1 s_access
            |-> prdata_out == {31'h0, integration_mode_out})
        else $error("integration readback wrong");

    // Bus view lags the pins by two edges; the pins may move in the access cycle
    chk_auth_sync: assert property (
        $stable(auth_state_in) [*3] ##0 s_rd_setup_at(OFF_AUTH_STATE)
            |=> prdata_out[7:0] == $past(auth_state_in))
        else $error("auth state not synchronised");

    chk_access_answered: assert property (
        psel_in && !penable_in ##1 s_access |-> pready_out && !pslverr_out)
        else $error("word access not answered");

    chk_lock_impl_bit: assert property (
        s_rd_setup_at(OFF_LOCK_STATE) ##1 s_access |-> prdata_out[LOCK_IMPL_BIT] == LOCK_IMPL)
        else $error("lock implemented bit wrong");

    chk_lock_access_raz: assert property (
        s_rd_setup_at(OFF_LOCK_ACCESS) ##1 s_access |-> prdata_out == 32'h0)
        else $error("lock access word not read as zero");

    chk_claim_readback: assert property (
        s_rd_setup_at(OFF_CLAIM_CLR) ##1 s_access |-> prdata_out == claim_tags_out)
        else $error("claim tag readback wrong");

    chk_ident_class: assert property (
        s_rd_setup_at(OFF_COMP_ID1) ##1 s_access
            |-> prdata_out == {24'h0, COMP_CLASS, PREAMBLE[11:8]})
        else $error("class ident word wrong");

    chk_arch_word: assert property (
        s_rd_setup_at(OFF_DEV_ARCH) ##1 s_access |-> prdata_out == DEV_ARCH)
        else $error("architecture word wrong");

    // Read data is a flop; it must not drift between reads
    chk_prdata_holds: assert property (
        !rd_setup |=> $stable(prdata_out))
        else $error("read data moved without a read");

    chk_device_space_empty: assert property (
        (psel_in && !penable_in && !pwrite_in && top_blk && word_off < OFF_INTEG_CTRL)
            ##1 s_access |-> prdata_out == 32'h0)
        else $error("device-specific space returned data");

    chk_low_block_no_write: assert property (
        psel_in && penable_in && pwrite_in && !top_blk
            |=> $stable(integration_mode_out) && $stable(claim_tags_out) && $stable(locked_out))
        else $error("lower block write changed state");

endmodule

// file: dcid_apb_host.sv
`timescale 1ns/10ps
module dcid_apb_host (
    // Clock
    input  wire logic        ref_clk_in,
    // Answer from the register bank
    input  wire logic        pready_in,
    input  wire logic        pslverr_in,
    input  wire logic [31:0] prdata_in,
    // Request toward the register bank
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [12:0]      paddr_out,
    output logic [31:0]      pwdata_out,
    output logic [3:0]       pstrb_out,
    output logic             hung_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 13'h0000;
        pwdata_out = 32'h0000_0000;
        pstrb_out = 4'h0;
        hung_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One 32-bit word per transfer with its byte strobes, setup then access phase
    task automatic xfer(input logic wr, input logic [12:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [31:0] rdata,
                        output logic err);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        psel_out = 1'b1;
        penable_out = 1'b0;
        pwrite_out = wr;
        paddr_out = addr;
        pwdata_out = data;
        pstrb_out = strb;
        @(negedge ref_clk_in);
        penable_out = 1'b1;
        @(posedge ref_clk_in);
        while (pready_in !== 1'b1 && n < 16) begin
            n++;
            @(posedge ref_clk_in);
        end
        if (n == 16) hung_out = 1'b1;
        rdata = prdata_in;
        err = pslverr_in;
        @(negedge ref_clk_in);
        // Released address, data and strobe lines must not echo the last request; pwrite keeps it
        psel_out = 1'b0;
        penable_out = 1'b0;
        paddr_out = ~addr;
        pwdata_out = ~data;
        pstrb_out = ~strb;
    endtask
endmodule

// file: dcid_regbank_tb.sv
`timescale 1ns/10ps
module dcid_regbank_tb;
    import dcid_pkg::*;
    localparam logic [31:0] KEY = 32'h5A5A_5A5A;
    // Arbitrary identification and configuration values
    localparam logic [63:0] PIDS = 64'h8877_6655_4433_2211;
    localparam logic [27:0] PRE = 28'hABC_DEF5;
    localparam logic [31:0] AFF0 = 32'h1357_9BDF;
    localparam logic [31:0] ARCH = 32'h0F1E_2D3C;
    localparam logic [31:0] CFG = 32'h00D4_E5F6;
    localparam logic [11:0] RO_OFF [19] = '{12'hFA8, 12'hFAC, 12'hFBC, 12'hFC0, 12'hFC4,
        12'hFC8, 12'hFCC, 12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC, 12'hFE0, 12'hFE4, 12'hFE8,
        12'hFEC, 12'hFF0, 12'hFF4, 12'hFF8, 12'hFFC};
    localparam logic [31:0] RO_EXP [19] = '{AFF0, ~AFF0, ARCH, CFG, ~CFG, CFG ^ AFF0,
        32'h47, {24'h0, PIDS[39:32]}, {24'h0, PIDS[47:40]}, {24'h0, PIDS[55:48]},
        {24'h0, PIDS[63:56]}, {24'h0, PIDS[7:0]}, {24'h0, PIDS[15:8]}, {24'h0, PIDS[23:16]},
        {24'h0, PIDS[31:24]}, {24'h0, PRE[7:0]}, {24'h0, CLASS_DEBUG, PRE[11:8]},
        {24'h0, PRE[19:12]}, {24'h0, PRE[27:20]}};

    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, integ, locked, hung, err;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, claim, rdata;
    logic [3:0]  pstrb;
    logic [7:0]  auth;
    int          failures, tests_run;

    dcid_regbank #(.ADDR_W(13), .NUM_BLOCKS(2), .CLAIM_W(12), .LOCK_IMPL(1'b1), .LOCK_KEY(KEY),
        .DEV_AFF0(AFF0), .DEV_AFF1(~AFF0), .DEV_ARCH(ARCH), .DEV_CFG0(CFG ^ AFF0),
        .DEV_CFG1(~CFG), .DEV_CFG2(CFG), .DEV_TYPE(8'h47), .PERIPH_IDS(PIDS),
        .COMP_CLASS(CLASS_DEBUG), .PREAMBLE(PRE)) dut (.ref_clk_in(ref_clk), .rst_in(rst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .auth_state_in(auth), .integration_mode_out(integ),
        .claim_tags_out(claim), .locked_out(locked));

    dcid_apb_host u_host (.ref_clk_in(ref_clk), .pready_in(pready), .pslverr_in(pslverr),
        .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb), .hung_out(hung));

    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Checks run: %0d, mismatches: %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
        // A hung transfer ends the run here
        if (hung === 1'b1) begin
            failures++;
            $display("Error at %0t: bus transfer hung", $time);
            give_verdict();
        end
    endtask

    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, 4'h0, rdata, err);
        chk(rdata, e);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s);
        u_host.xfer(1'b1, a, d, s, rdata, err);
        chk({31'h0, err}, 32'h0);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        auth = 8'hC3;
        failures = 0;
        tests_run = 0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk({integ, locked, claim}, 34'h1_0000_0000);
        rd(13'h1FB4, 32'h3);
        rd(13'h1FB8, 32'hC3);
        wr(13'h1F00, 32'h1, 4'hF);
        chk({31'h0, integ}, 32'h0);
        wr(13'h1FB0, KEY, 4'h7);
        rd(13'h1FB4, 32'h3);
        wr(13'h1FB0, KEY, 4'hF);
        rd(13'h1FB4, 32'h1);
        rd(13'h1FB0, 32'h0);
        wr(13'h1F00, 32'hFFFF_FFFF, 4'hE);
        chk({31'h0, integ}, 32'h0);
        wr(13'h1F00, 32'hFFFF_FFFF, 4'hF);
        rd(13'h1F00, 32'h1);
        rd(13'h1FA0, 32'h0000_0FFF);
        wr(13'h1FA0, 32'hFFFF_FFFF, 4'h2);
        rd(13'h1FA4, 32'h0000_0F00);
        wr(13'h1FA0, 32'h0000_00FF, 4'h1);
        chk(claim, 32'h0000_0FFF);
        wr(13'h1FA4, 32'hFFFF_FA5A, 4'hF);
        rd(13'h1FA4, 32'h0000_05A5);
        wr(13'h0FA0, 32'hFFFF_FFFF, 4'hF);
        wr(13'h0F00, 32'h0, 4'hF);
        rd(13'h1FA4, 32'h0000_05A5);
        rd(13'h0FF4, 32'h0);
        chk({31'h0, integ}, 32'h1);
        rd(13'h1000, 32'h0);
        wr(13'h1F04, 32'hFFFF_FFFF, 4'hF);
        rd(13'h1F04, 32'h0);
        for (int i = 0; i < 19; i++) begin
            wr({1'b1, RO_OFF[i]}, 32'hFFFF_FFFF, 4'hF);
            rd({1'b1, RO_OFF[i]}, RO_EXP[i]);
        end
        @(negedge ref_clk);
        auth = 8'h5A;
        repeat (3) @(posedge ref_clk);
        rd(13'h1FB8, 32'h5A);
        wr(13'h1FB0, 32'h0, 4'hF);
        rd(13'h1FB4, 32'h3);
        wr(13'h1F00, 32'h0, 4'hF);
        wr(13'h1FA4, 32'hFFFF_FFFF, 4'hF);
        chk({integ, claim}, 33'h1_0000_05A5);
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk({integ, locked, claim}, 34'h1_0000_0000);
        give_verdict();
    end
endmodule
